//--- core/audio_clock_map.svh
`ifndef AUDIO_CLOCK_MAP_SVH
`define AUDIO_CLOCK_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define ADDR_CPF_LOW 8'h30
`define ADDR_CPF_MID 8'h31
`define ADDR_CPF_HIGH 8'h32
`define ADDR_STEP_LOW 8'h34
`define ADDR_STEP_MID 8'h35
`define ADDR_STEP_HIGH 8'h36
`define ADDR_BIT_RATIO 8'h38
`define ADDR_CHAN_RATIO 8'h39
`define ADDR_CONTROL 8'h3A

// ****************************************************************
// field widths and positions
// ****************************************************************
`define CPF_W 18
`define CPF_HIGH_W 2
`define STEP_W 22
`define STEP_HIGH_W 6
`define RATIO_W 6
`define CTRL_W 4
`define CTRL_LOOP_OPEN 3
`define CTRL_VREF_SRC 2
`define CTRL_CHAN_PHASE 1
`define CTRL_BIT_PHASE 0

// ****************************************************************
// reset values and loop constants
// ****************************************************************
`define CPF_RESET 18'h00000
`define STEP_RESET 22'h000000
`define RATIO_RESET 6'h00
`define CTRL_RESET 4'h0
`define BYTE_RESET 8'h00
`define CPF_HIGH_RESET 2'h0
`define STEP_HIGH_RESET 6'h00
`define UNMAPPED_READ 8'h00
`define CORR_UNIT 22'h000001
`define ACC_W 24

`endif

//--- core/audio_clock_pkg.sv
package audio_clock_pkg;

  typedef enum logic [1:0] {
    LOOP_OPEN = 2'b00,
    LOOP_ACQUIRE = 2'b01,
    LOOP_TRACK = 2'b11
  } loop_state_t;

endpackage : audio_clock_pkg

//--- core/edge_divider.sv
`timescale 1ns/1ps
`include "audio_clock_map.svh"

module edge_divider #(
  parameter int RATIO_W = `RATIO_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic srcRise,
  input wire logic srcFall,
  input wire logic useRise,
  input wire logic [RATIO_W-1:0] ratio,
  output logic clkOut,
  output logic risePulse,
  output logic fallPulse
);

  logic [RATIO_W-1:0] cnt_r;
  logic [RATIO_W-1:0] half;
  logic [RATIO_W-1:0] last;
  logic trig;
  logic atWrap;
  logic toggle;

  // ****************************************************************
  // divide on the selected source edge; period is ratio source cycles, or two when ratio is below 2
  // ****************************************************************
  assign trig = useRise ? srcRise : srcFall;
  assign half = ratio >> 1;
  assign last = (ratio == '0) ? '0 : ratio - 1'b1;
  assign atWrap = (cnt_r >= last);
  assign toggle = trig & (atWrap | (cnt_r == half - 1'b1 && half != '0));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      clkOut <= 1'b0;
      risePulse <= 1'b0;
      fallPulse <= 1'b0;
    end else begin
      if (trig) begin
        cnt_r <= atWrap ? '0 : cnt_r + 1'b1;
      end
      clkOut <= clkOut ^ toggle;
      risePulse <= toggle & ~clkOut;
      fallPulse <= toggle & clkOut;
    end
  end

endmodule : edge_divider

//--- core/field_locked_audio_clock_gen.sv
`timescale 1ns/1ps
`include "audio_clock_map.svh"

// Behaviour
// R01 - hold 18-bit per-field master cycle count over three bytes, two bits in third
// R02 - hold 22-bit nominal step over three bytes, six bits in the third
// R03 - bit clock divides master clock by 6-bit ratio in its own byte, by 2 when ratio is below 2
// R04 - channel-select clock divides bit clock by 6-bit ratio in its own byte, by 2 when ratio is below 2
// R05 - loop-mode 0 locks master clock to fields; 1 leaves it free-running
// R06 - vertical reference from internal decoder on 0, expansion input on 1
// R07 - channel-select edges follow bit clock falling edges on 0, rising on 1
// R08 - bit clock edges follow master clock falling edges on 0, rising on 1
// R09 - phase accumulator steps by nominal; locked mode corrects once per field
// R10 - multi-byte settings apply coherently, never half written
module field_locked_audio_clock_gen
  import audio_clock_pkg::*;
#(
  parameter int CPF_W = `CPF_W,
  parameter int STEP_W = `STEP_W,
  parameter int RATIO_W = `RATIO_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData,
  input wire logic decoderVerticalRef,
  input wire logic expansion_vertical_ref_input,
  output logic audio_master_clock,
  output logic audio_bit_clock,
  output logic channel_select_clock,
  output logic loopLocked
);

  // ****************************************************************
  // register storage
  // ****************************************************************
  logic [7:0] cpfLow_r;
  logic [7:0] cpfMid_r;
  logic [`CPF_HIGH_W-1:0] cpfHigh_r;
  logic [7:0] stepLow_r;
  logic [7:0] stepMid_r;
  logic [`STEP_HIGH_W-1:0] stepHigh_r;
  logic [RATIO_W-1:0] bit_clock_divider;
  logic [RATIO_W-1:0] channel_select_divider;
  logic [`CTRL_W-1:0] control_r;

  logic [CPF_W-1:0] cyclesActive_r;
  logic [STEP_W-1:0] stepActive_r;
  logic pending_r;

  logic audio_loop_open;
  logic vertical_ref_source;
  logic channel_select_phase;
  logic bit_clock_phase;

  assign audio_loop_open = control_r[`CTRL_LOOP_OPEN];
  assign vertical_ref_source = control_r[`CTRL_VREF_SRC];
  assign channel_select_phase = control_r[`CTRL_CHAN_PHASE];
  assign bit_clock_phase = control_r[`CTRL_BIT_PHASE];

  // ****************************************************************
  // write decode
  // ****************************************************************
  logic wrCpfLow;
  logic wrCpfMid;
  logic wrCpfHigh;
  logic wrStepLow;
  logic wrStepMid;
  logic wrStepHigh;
  logic wrBitRatio;
  logic wrChanRatio;
  logic wrControl;

  assign wrCpfLow = regWrite && regAddr == `ADDR_CPF_LOW;
  assign wrCpfMid = regWrite && regAddr == `ADDR_CPF_MID;
  assign wrCpfHigh = regWrite && regAddr == `ADDR_CPF_HIGH;
  assign wrStepLow = regWrite && regAddr == `ADDR_STEP_LOW;
  assign wrStepMid = regWrite && regAddr == `ADDR_STEP_MID;
  assign wrStepHigh = regWrite && regAddr == `ADDR_STEP_HIGH;
  assign wrBitRatio = regWrite && regAddr == `ADDR_BIT_RATIO;
  assign wrChanRatio = regWrite && regAddr == `ADDR_CHAN_RATIO;
  assign wrControl = regWrite && regAddr == `ADDR_CONTROL;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpfLow_r <= `BYTE_RESET;
      cpfMid_r <= `BYTE_RESET;
      cpfHigh_r <= `CPF_HIGH_RESET;
      stepLow_r <= `BYTE_RESET;
      stepMid_r <= `BYTE_RESET;
      stepHigh_r <= `STEP_HIGH_RESET;
      bit_clock_divider <= `RATIO_RESET;
      channel_select_divider <= `RATIO_RESET;
      control_r <= `CTRL_RESET;
    end else begin
      if (wrCpfLow) cpfLow_r <= regWriteData; // see R01
      if (wrCpfMid) cpfMid_r <= regWriteData; // see R01
      if (wrCpfHigh) cpfHigh_r <= regWriteData[`CPF_HIGH_W-1:0]; // see R01
      if (wrStepLow) stepLow_r <= regWriteData; // see R02
      if (wrStepMid) stepMid_r <= regWriteData; // see R02
      if (wrStepHigh) stepHigh_r <= regWriteData[`STEP_HIGH_W-1:0]; // see R02
      if (wrBitRatio) bit_clock_divider <= regWriteData[RATIO_W-1:0]; // see R03
      if (wrChanRatio) channel_select_divider <= regWriteData[RATIO_W-1:0]; // see R04
      if (wrControl) control_r <= regWriteData[`CTRL_W-1:0];
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  logic [7:0] readMux;

  assign readMux =
    (regAddr == `ADDR_CPF_LOW) ? cpfLow_r :
    (regAddr == `ADDR_CPF_MID) ? cpfMid_r :
    (regAddr == `ADDR_CPF_HIGH) ? {{(8-`CPF_HIGH_W){1'b0}}, cpfHigh_r} :
    (regAddr == `ADDR_STEP_LOW) ? stepLow_r :
    (regAddr == `ADDR_STEP_MID) ? stepMid_r :
    (regAddr == `ADDR_STEP_HIGH) ? {{(8-`STEP_HIGH_W){1'b0}}, stepHigh_r} :
    (regAddr == `ADDR_BIT_RATIO) ? {{(8-RATIO_W){1'b0}}, bit_clock_divider} :
    (regAddr == `ADDR_CHAN_RATIO) ? {{(8-RATIO_W){1'b0}}, channel_select_divider} :
    (regAddr == `ADDR_CONTROL) ? {{(8-`CTRL_W){1'b0}}, control_r} :
    `UNMAPPED_READ;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regReadData <= `BYTE_RESET;
    end else begin
      regReadData <= readMux;
    end
  end

  // ****************************************************************
  // vertical reference selection and field edge
  // ****************************************************************
  logic xrvMeta_r;
  logic xrvSync_r;
  logic vrefSel;
  logic vrefPrev_r;
  logic fieldStart;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xrvMeta_r <= 1'b0;
      xrvSync_r <= 1'b0;
      vrefPrev_r <= 1'b0;
    end else begin
      xrvMeta_r <= expansion_vertical_ref_input;
      xrvSync_r <= xrvMeta_r;
      vrefPrev_r <= vrefSel;
    end
  end

  // only the second flop feeds the selector; the expansion pin is asynchronous
  assign vrefSel = vertical_ref_source ? xrvSync_r : decoderVerticalRef; // see R06
  assign fieldStart = vrefSel & ~vrefPrev_r;

  // ****************************************************************
  // coherent commit of multi-byte settings
  // ****************************************************************
  logic highWrite;
  logic commitNow;

  // the high byte arms the commit, so a half-written value never drives the generator
  assign highWrite = wrCpfHigh | wrStepHigh;
  assign commitNow = pending_r & (fieldStart | audio_loop_open); // see R10

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending_r <= 1'b0;
      cyclesActive_r <= `CPF_RESET;
      stepActive_r <= `STEP_RESET;
    end else begin
      pending_r <= highWrite | (pending_r & ~commitNow);
      if (commitNow) begin
        cyclesActive_r <= {cpfHigh_r, cpfMid_r, cpfLow_r}; // see R10
        stepActive_r <= {stepHigh_r, stepMid_r, stepLow_r}; // see R10
      end
    end
  end

  // ****************************************************************
  // loop control
  // ****************************************************************
  loop_state_t state_r;
  loop_state_t state_nxt;
  logic [CPF_W-1:0] fieldCount_r;
  logic [STEP_W-1:0] corr_r;
  logic [STEP_W-1:0] corr_nxt;
  logic [STEP_W-1:0] stepNow;
  logic mclkRise;
  logic mclkFall;
  logic countLow;
  logic countHigh;

  assign countLow = fieldCount_r < cyclesActive_r;
  assign countHigh = fieldCount_r > cyclesActive_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      LOOP_OPEN: begin
        if (!audio_loop_open) begin
          state_nxt = LOOP_ACQUIRE;
        end
      end
      LOOP_ACQUIRE: begin
        if (audio_loop_open) begin
          state_nxt = LOOP_OPEN;
        end else if (fieldStart) begin
          state_nxt = LOOP_TRACK;
        end
      end
      LOOP_TRACK: begin
        if (audio_loop_open) begin
          state_nxt = LOOP_OPEN;
        end
      end
      default: begin
        state_nxt = LOOP_OPEN;
      end
    endcase
  end

  // once per field nudge the step toward the programmed cycle count
  assign corr_nxt =
    (state_r != LOOP_TRACK) ? '0 :
    !fieldStart ? corr_r :
    countLow ? corr_r + `CORR_UNIT :
    countHigh ? corr_r - `CORR_UNIT :
    corr_r; // see R09, see R05

  assign stepNow = stepActive_r + corr_r; // see R09

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= LOOP_OPEN;
      corr_r <= '0;
      fieldCount_r <= '0;
      loopLocked <= 1'b0;
    end else begin
      state_r <= state_nxt;
      corr_r <= corr_nxt;
      if (fieldStart) begin
        fieldCount_r <= {{(CPF_W-1){1'b0}}, mclkRise};
      end else if (mclkRise) begin
        fieldCount_r <= fieldCount_r + 1'b1;
      end
      if (state_r != LOOP_TRACK) begin
        loopLocked <= 1'b0;
      end else if (fieldStart) begin
        loopLocked <= !countLow && !countHigh; // see R05
      end
    end
  end

  // ****************************************************************
  // clock generation chain
  // ****************************************************************
  logic bclkRise;
  logic bclkFall;

  phase_accum #(
    .ACC_W(`ACC_W),
    .STEP_W(STEP_W)
  ) masterGen (
    .clk(clk),
    .rst(rst),
    .step(stepNow),
    .clkOut(audio_master_clock),
    .risePulse(mclkRise),
    .fallPulse(mclkFall)
  ); // see R09

  edge_divider #(
    .RATIO_W(RATIO_W)
  ) bitDiv (
    .clk(clk),
    .rst(rst),
    .srcRise(mclkRise),
    .srcFall(mclkFall),
    .useRise(bit_clock_phase),
    .ratio(bit_clock_divider),
    .clkOut(audio_bit_clock),
    .risePulse(bclkRise),
    .fallPulse(bclkFall)
  ); // see R03, see R08

  edge_divider #(
    .RATIO_W(RATIO_W)
  ) chanDiv (
    .clk(clk),
    .rst(rst),
    .srcRise(bclkRise),
    .srcFall(bclkFall),
    .useRise(channel_select_phase),
    .ratio(channel_select_divider),
    .clkOut(channel_select_clock),
    .risePulse(),
    .fallPulse()
  ); // see R04, see R07

endmodule : field_locked_audio_clock_gen

//--- core/phase_accum.sv
`timescale 1ns/1ps
`include "audio_clock_map.svh"

module phase_accum #(
  parameter int ACC_W = `ACC_W,
  parameter int STEP_W = `STEP_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [STEP_W-1:0] step,
  output logic clkOut,
  output logic risePulse,
  output logic fallPulse
);

  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;
  logic newMsb;

  // ****************************************************************
  // accumulator; msb is the synthesised master clock
  // ****************************************************************
  assign acc_nxt = acc_r + {{(ACC_W-STEP_W){1'b0}}, step};
  assign newMsb = acc_nxt[ACC_W-1];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_r <= '0;
      clkOut <= 1'b0;
      risePulse <= 1'b0;
      fallPulse <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      clkOut <= newMsb;
      risePulse <= newMsb & ~acc_r[ACC_W-1];
      fallPulse <= ~newMsb & acc_r[ACC_W-1];
    end
  end

endmodule : phase_accum

//--- sim/audio_capture_model.sv
`timescale 1ns/1ps
// ****************************************
// capture side: edge counts per channel period
// ****************************************
module audio_capture_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic masterClk,
  input wire logic bitClk,
  input wire logic chanClk,
  output int masterPer,
  output int bitPer,
  output int chanRises,
  output int masterRises
);
  logic mPrev, bPrev, cPrev;
  int mCnt, bCnt;
  wire mUp = masterClk & !mPrev;
  wire bUp = bitClk & !bPrev;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {mPrev, bPrev, cPrev} <= 3'h0;
      {mCnt, bCnt, masterPer, bitPer, chanRises, masterRises} <= '0;
    end else begin
      {mPrev, bPrev, cPrev} <= {masterClk, bitClk, chanClk};
      masterRises <= masterRises + int'(mUp);
      if (chanClk && !cPrev) begin
        masterPer <= mCnt;
        bitPer <= bCnt;
        mCnt <= int'(mUp);
        bCnt <= int'(bUp);
        chanRises <= chanRises + 1;
      end else begin
        mCnt <= mCnt + int'(mUp);
        bCnt <= bCnt + int'(bUp);
      end
    end
  end
endmodule : audio_capture_model

//--- sim/audio_clock_checker_sva.sv
`timescale 1ns/1ps
// ****************************************
// audio clock checks
// ****************************************
module audio_clock_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWriteData,
  input wire logic [7:0] regReadData,
  input wire logic decoderVerticalRef,
  input wire logic expansion_vertical_ref_input,
  input wire logic audio_master_clock,
  input wire logic audio_bit_clock,
  input wire logic channel_select_clock,
  input wire logic loopLocked
);
  logic [3:0] ctrl_r;
  logic [3:0] mHist_r;
  logic [3:0] bHist_r;
  logic [1:0] refPrev_r;
  logic [3:0] decAge_r;
  logic [3:0] expAge_r;
  wire [4:0] mWin = {mHist_r, audio_master_clock};
  wire [4:0] bWin = {bHist_r, audio_bit_clock};
  wire mRise = |(mWin[3:0] & ~mWin[4:1]);
  wire mFall = |(~mWin[3:0] & mWin[4:1]);
  wire bRise = |(bWin[3:0] & ~bWin[4:1]);
  wire bFall = |(~bWin[3:0] & bWin[4:1]);
  wire mapped = regAddr inside {8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36, 8'h38, 8'h39, 8'h3A};
  wire fullByte = regAddr inside {8'h30, 8'h31, 8'h34, 8'h35};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= 4'h0;
      mHist_r <= 4'h0;
      bHist_r <= 4'h0;
      refPrev_r <= 2'h0;
      decAge_r <= 4'hF;
      expAge_r <= 4'hF;
    end else begin
      if (regWrite && regAddr == 8'h3A) begin
        ctrl_r <= regWriteData[3:0];
      end
      mHist_r <= mWin[3:0];
      bHist_r <= bWin[3:0];
      refPrev_r <= {expansion_vertical_ref_input, decoderVerticalRef};
      decAge_r <= (decoderVerticalRef && !refPrev_r[0]) ? 4'h0 : decAge_r + {3'h0, decAge_r != 4'hF};
      expAge_r <= (expansion_vertical_ref_input && !refPrev_r[1]) ? 4'h0 : expAge_r + {3'h0, expAge_r != 4'hF};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_BIT_EDGE: assert property ($changed(audio_bit_clock) |-> (ctrl_r[0] ? mRise : mFall))
    else $error("bit clock moved without selected master edge");
  AST_CHAN_EDGE: assert property ($changed(channel_select_clock) |-> (ctrl_r[1] ? bRise : bFall))
    else $error("channel clock moved without selected bit edge");
  AST_CPF_HIGH: assert property ($past(regAddr) == 8'h32 |-> regReadData[7:2] == 6'h00)
    else $error("unused count bits read nonzero");
  AST_STEP_HIGH: assert property ($past(regAddr) == 8'h36 |-> regReadData[7:6] == 2'h0)
    else $error("unused step bits read nonzero");
  AST_BIT_RATIO_HIGH: assert property ($past(regAddr) == 8'h38 |-> regReadData[7:6] == 2'h0)
    else $error("unused bit ratio bits read nonzero");
  AST_CHAN_RATIO_HIGH: assert property ($past(regAddr) == 8'h39 |-> regReadData[7:6] == 2'h0)
    else $error("unused channel ratio bits read nonzero");
  AST_READBACK: assert property (regWrite && fullByte ##1 !regWrite && $stable(regAddr) |=> regReadData == $past(regWriteData, 2))
    else $error("written byte not read back");
  AST_UNMAPPED: assert property (!$past(mapped) |-> regReadData == 8'h00)
    else $error("unmapped address read nonzero");
  AST_LOCK_SRC: assert property ($rose(loopLocked) |-> (ctrl_r[2] ? expAge_r <= 4'h9 : decAge_r <= 4'h6))
    else $error("lock rose without field start of selected source");
  COV_LOCK: cover property ($rose(loopLocked));
  COV_CHAN: cover property ($rose(channel_select_clock) && ctrl_r[1]);
  COV_READBACK: cover property (regWrite && fullByte);
endmodule : audio_clock_checker

bind field_locked_audio_clock_gen audio_clock_checker chk (
  .clk(clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite), .regWriteData(regWriteData),
  .regReadData(regReadData), .decoderVerticalRef(decoderVerticalRef),
  .expansion_vertical_ref_input(expansion_vertical_ref_input), .audio_master_clock(audio_master_clock),
  .audio_bit_clock(audio_bit_clock), .channel_select_clock(channel_select_clock), .loopLocked(loopLocked)
);

//--- sim/field_locked_audio_clock_gen_tb.sv
`timescale 1ns/1ps
// ****************************************
// testbench
// ****************************************
module field_locked_audio_clock_gen_tb;
  logic clk, rst, regWrite, decRef, expRef, masterClk, bitClk, chanClk, loopLocked;
  logic [7:0] regAddr, regWriteData, regReadData;
  int masterPer, bitPer, chanRises, masterRises;
  int errTotal = 0;
  int checksDone = 0;
  int cycles = 0;
  logic [7:0] addrs [9] = '{8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36, 8'h38, 8'h39, 8'h3A};
  logic [7:0] masks [9] = '{8'hFF, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'h3F, 8'h0F};
  logic [7:0] bRat [4] = '{8'h04, 8'h00, 8'h06, 8'h3F};
  logic [7:0] cRat [4] = '{8'h02, 8'h03, 8'h01, 8'h02};

  field_locked_audio_clock_gen dut (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite), .regWriteData(regWriteData),
    .regReadData(regReadData), .decoderVerticalRef(decRef), .expansion_vertical_ref_input(expRef),
    .audio_master_clock(masterClk), .audio_bit_clock(bitClk), .channel_select_clock(chanClk),
    .loopLocked(loopLocked)
  );
  audio_capture_model partner (
    .clk(clk), .rst(rst), .masterClk(masterClk), .bitClk(bitClk), .chanClk(chanClk),
    .masterPer(masterPer), .bitPer(bitPer), .chanRises(chanRises), .masterRises(masterRises)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic giveVerdict();
    $display("comparisons %0d mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : giveVerdict

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errTotal++;
      giveVerdict();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWriteData = d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    regAddr = a;
    repeat (2) @(negedge clk);
    check($sformatf("register %0h", a), {24'h0, regReadData}, {24'h0, exp});
  endtask : rd

  task automatic waitChan();
    int n;
    n = chanRises;
    for (int k = 0; k < 6000 && chanRises < n + 3; k++) begin
      @(negedge clk);
    end
  endtask : waitChan

  task automatic fields(input int n, input bit useExp);
    repeat (n) begin
      if (useExp) expRef = 1'b1;
      else decRef = 1'b1;
      repeat (4) @(negedge clk);
      decRef = 1'b0;
      expRef = 1'b0;
      repeat (796) @(negedge clk);
    end
  endtask : fields

  function automatic int span(input logic [7:0] r);
    return (r < 8'h02) ? 2 : int'(r);
  endfunction : span

  initial begin
    int mr;
    {rst, regWrite, decRef, expRef} = 4'h8;
    regAddr = 8'h00;
    regWriteData = 8'h00;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    foreach (addrs[i]) begin
      wr(addrs[i], 8'hFF);
      rd(addrs[i], masks[i]);
    end
    wr(8'h33, 8'hFF);
    rd(8'h33, 8'h00);
    wr(8'h34, 8'h00);
    wr(8'h35, 8'h00);
    wr(8'h36, 8'h00);
    wr(8'h34, 8'hFF);
    wr(8'h35, 8'hFF);
    mr = masterRises;
    repeat (100) @(negedge clk);
    check("master idle", masterRises, mr);
    wr(8'h34, 8'h00);
    wr(8'h35, 8'h00);
    for (int r = 0; r < 4; r++) begin
      wr(8'h36, 8'h00);
      wr(8'h38, bRat[r]);
      wr(8'h39, cRat[r]);
      wr(8'h3A, 8'h08 | 8'(r));
      wr(8'h36, 8'h20);
      waitChan();
      check("master per channel", masterPer, span(bRat[r]) * span(cRat[r]));
      check("bit per channel", bitPer, span(cRat[r]));
    end
    wr(8'h36, 8'h00);
    wr(8'h3A, 8'h00);
    wr(8'h30, 8'h64);
    wr(8'h31, 8'h00);
    wr(8'h32, 8'h00);
    wr(8'h36, 8'h20);
    fields(6, 1'b0);
    check("locked on decoder", loopLocked, 1);
    wr(8'h3A, 8'h04);
    wr(8'h30, 8'h65);
    wr(8'h32, 8'h00);
    fields(3, 1'b0);
    check("lock ignores decoder", loopLocked, 1);
    fields(3, 1'b1);
    check("unlocked on expansion", loopLocked, 0);
    giveVerdict();
  end
endmodule : field_locked_audio_clock_gen_tb
